//--- wkr_defines.svh
// constants for the watchdog and reset-key block
`ifndef WKR_DEFINES_SVH
`define WKR_DEFINES_SVH

// clock rates and delays in their own units
`define WKR_CLK_HZ          200000000
`define WKR_SLOW_RC_OSCILLATOR_HZ         32000
`define WKR_PWRON_MS        50
// derived cycle counts
`define WKR_SLOW_RC_OSCILLATOR_DIV        (`WKR_CLK_HZ / `WKR_SLOW_RC_OSCILLATOR_HZ)
`define WKR_PWRON_CYC       (`WKR_CLK_HZ / 1000 * `WKR_PWRON_MS)
// slow ticks seen after a bad key before the reset fires
`define WKR_KEY_DLY_TICKS   2'd3

// register word indices (byte address / 4) inside the 4 KB window
`define WKR_OFS_WDOG_CTRL   10'h000
`define WKR_OFS_RST_CAUSE   10'h001
`define WKR_OFS_RST_KEY     10'h002
`define WKR_OFS_STATUS      10'h003

// watchdog_control fields
`define WKR_ENKEY_MSB       7
`define WKR_ENKEY_LSB       3
`define WKR_PSEL_MSB        2
`define WKR_PSEL_LSB        0

// key values
`define WKR_ENKEY_OFF       5'h15
`define WKR_ENKEY_ON        5'h0a
`define WKR_RKEY_A          8'h55
`define WKR_RKEY_B          8'haa

// reset values
`define WKR_WDOG_CTRL_RST   8'h53
`define WKR_RST_KEY_RST     8'h55

// reset_cause_flags bit positions
`define WKR_BIT_ENKEY_FAULT 0
`define WKR_BIT_VKEY_FAULT  1
`define WKR_BIT_BROWNOUT    2
`define WKR_BIT_CKEY_FAULT  3
// status bit positions
`define WKR_BIT_TIMEOUT     0
`define WKR_BIT_PDOWN       1

// watchdog counter width, enough for the longest period
`define WKR_WDOG_W          18

`endif

//--- wkr_pkg.sv
// types shared by the watchdog and reset-key block
package wkr_pkg;

  // reset sequencer states
  typedef enum logic {
    WKR_RUN  = 1'b0,
    WKR_HOLD = 1'b1
  } wkr_rst_state_t;

  // register selected by a bus address
  typedef enum logic [2:0] {
    WKR_SEL_NONE  = 3'b000,
    WKR_SEL_CTRL  = 3'b001,
    WKR_SEL_CAUSE = 3'b010,
    WKR_SEL_KEY   = 3'b011,
    WKR_SEL_STAT  = 3'b100
  } wkr_reg_sel_t;

endpackage

//--- wkr_watchdog_reset.sv
// watchdog timer with key-protected control and reset-cause flags
//
// Behaviour
// [R1] watchdog counts slow 32 kHz ticks, dividing by 2^8 to 2^18
// [R2] period_select codes 000..111 give 2^8,10,12,14,15,16,17,18 ticks
// [R3] enable key 10101B stops the watchdog, 01010B runs it
// [R4] any other enable key resets the device after 2 to 3 slow ticks
// [R5] bad enable key sets cause bit 0; power-on or software writing 0 clears
// [R6] power-on control value is 0x53: watchdog on, period code 011
// [R7] overflow in normal mode: full reset and timeout flag set
// [R8] overflow in sleep or idle: timeout flag, clear only PC and SP
// [R9] count cleared by bad-key reset, clear instruction or halt
// [R10] reset key 0x55 or 0xaa does nothing, else reset after 2-3 ticks
// [R11] reset key register powers up as 0x55
// [R12] bad reset key sets cause bit 3
// [R13] cause bits 7 to 4 read as zero
// [R14] power-on reset forces program counter to zero
// [R15] power-on reset sets port data and control registers to ones
// [R16] reset is released only after a 50 ms power-on delay
// [R17] brownout indication causes a full reset
// [R18] halt clears the count; it resumes only if enabled
// [R19] halt sets power-down flag; power-up or clear instruction clears it
// [R20] free-running tick counter overflows at selected count, clear zeros it
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wkr_defines.svh"

module wkr_watchdog_reset
  import wkr_pkg::*;
#(
  parameter int unsigned SLOW_RC_OSCILLATOR_DIV  = `WKR_SLOW_RC_OSCILLATOR_DIV,
  parameter int unsigned PWRON_CYC = `WKR_PWRON_CYC
) (
  input  wire logic        ref_clk,       // 200 MHz system clock
  input  wire logic        nrst,          // power-on reset, async
  input  wire logic        hsel,          // ahb slave select
  input  wire logic [31:0] haddr,         // ahb address
  input  wire logic [1:0]  htrans,        // ahb transfer type
  input  wire logic        hwrite,        // ahb write
  input  wire logic [2:0]  hsize,         // ahb size, word only
  input  wire logic [31:0] hwdata,        // ahb write data
  input  wire logic        hready,        // ahb bus ready
  output logic             hreadyout,     // ahb slave ready
  output logic             hresp,         // ahb response, always okay
  output logic [31:0]      hrdata,        // ahb read data
  input  wire logic        clear_watchdog_instruction_instr, // clear instruction pulse
  input  wire logic        halt_instr,    // halt instruction pulse
  input  wire logic        sleep_mode,    // cpu in sleep or idle
  input  wire logic        brownout_det,  // supply below threshold
  output logic             sys_rst_n,     // full device reset, low
  output logic             por_init,      // pc to zero, ports to ones
  output logic             pc_sp_clr      // clear pc and sp only
);

  localparam int DIV_W  = $clog2(SLOW_RC_OSCILLATOR_DIV);
  localparam int HOLD_W = $clog2(PWRON_CYC + 1);
  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(SLOW_RC_OSCILLATOR_DIV - 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(PWRON_CYC - 1);

  // bus address to register select
  function automatic wkr_reg_sel_t reg_decode(input logic [9:0] idx);
    wkr_reg_sel_t sel;
    sel = WKR_SEL_NONE;
    if (idx == `WKR_OFS_WDOG_CTRL) begin
      sel = WKR_SEL_CTRL;
    end else if (idx == `WKR_OFS_RST_CAUSE) begin
      sel = WKR_SEL_CAUSE;
    end else if (idx == `WKR_OFS_RST_KEY) begin
      sel = WKR_SEL_KEY;
    end else if (idx == `WKR_OFS_STATUS) begin
      sel = WKR_SEL_STAT;
    end
    return sel;
  endfunction

  // last count of the selected watchdog period
  // [R2] period table
  function automatic logic [`WKR_WDOG_W-1:0] period_last(
    input logic [2:0] psel
  );
    logic [`WKR_WDOG_W-1:0] last;
    last = '0;
    case (psel)
      3'h0: last = 18'h000ff;
      3'h1: last = 18'h003ff;
      3'h2: last = 18'h00fff;
      3'h3: last = 18'h03fff;
      3'h4: last = 18'h07fff;
      3'h5: last = 18'h0ffff;
      3'h6: last = 18'h1ffff;
      default: last = 18'h3ffff;
    endcase
    return last;
  endfunction

  wkr_rst_state_t          rst_state_reg;
  logic [HOLD_W-1:0]       hold_cnt_reg;
  logic [DIV_W-1:0]        div_cnt_reg;
  logic                    slow_tick_reg;
  logic [7:0]              wdog_ctrl_reg;
  logic [7:0]              rst_key_reg;
  logic [3:0]              cause_reg;
  logic [3:0]              cause_next;
  logic                    timeout_reg;
  logic                    pdown_reg;
  logic [`WKR_WDOG_W-1:0]  wdog_cnt_reg;
  logic                    pc_sp_clr_reg;
  logic                    ap_write_reg;
  wkr_reg_sel_t            ap_sel_reg;
  logic [31:0]             hrdata_reg;
  logic                    accept;
  logic                    holding;
  logic [4:0]              en_key;
  logic                    wdog_en;
  logic                    ovf;
  logic                    full_rst_req;
  logic [1:0]              key_bad;
  logic [1:0]              key_fire;
  logic [1:0]              key_cnt_reg [2];
  logic [7:0]              rd_val;

  assign holding = (rst_state_reg == WKR_HOLD);
  assign en_key  = wdog_ctrl_reg[`WKR_ENKEY_MSB:`WKR_ENKEY_LSB];
  // [R3] key enables
  assign wdog_en = (en_key == `WKR_ENKEY_ON);

  // [R1] slow tick divider
  // one-cycle enable stands in for the slow oscillator edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg   <= '0;
      slow_tick_reg <= 1'b0;
    end else if (div_cnt_reg == DIV_LAST) begin
      div_cnt_reg   <= '0;
      slow_tick_reg <= 1'b1;
    end else begin
      div_cnt_reg   <= div_cnt_reg + 1'b1;
      slow_tick_reg <= 1'b0;
    end
  end

  // bad key detection for the enable key and the reset key
  // [R4] invalid enable key
  assign key_bad[0] = (en_key != `WKR_ENKEY_ON) &&
                      (en_key != `WKR_ENKEY_OFF);
  // [R10] invalid reset key
  assign key_bad[1] = (rst_key_reg != `WKR_RKEY_A) &&
                      (rst_key_reg != `WKR_RKEY_B);

  // per-key delay counter; the third tick lands 2 to 3 periods later
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_key
      // [R4] delayed key reset
      assign key_fire[gi] = key_bad[gi] && !holding && slow_tick_reg &&
                            (key_cnt_reg[gi] == `WKR_KEY_DLY_TICKS - 2'd1);
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          key_cnt_reg[gi] <= 2'h0;
        end else if (!key_bad[gi] || holding) begin
          key_cnt_reg[gi] <= 2'h0;
        end else if (slow_tick_reg &&
                     key_cnt_reg[gi] != `WKR_KEY_DLY_TICKS) begin
          key_cnt_reg[gi] <= key_cnt_reg[gi] + 2'h1;
        end
      end
    end
  endgenerate

  // [R20] overflow at selected count
  // >= guards against a period shortened while counting past it
  assign ovf = wdog_en && slow_tick_reg && !holding &&
               (wdog_cnt_reg >= period_last(
                  wdog_ctrl_reg[`WKR_PSEL_MSB:`WKR_PSEL_LSB]));

  // [R7] normal overflow resets; [R17] brownout resets
  assign full_rst_req = brownout_det || (|key_fire) ||
                        (ovf && !sleep_mode);

  // reset sequencer: each cause restarts the power-on delay
  // [R16] power-on delay hold
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_state_reg <= WKR_HOLD;
      hold_cnt_reg  <= '0;
    end else if (full_rst_req) begin
      rst_state_reg <= WKR_HOLD;
      hold_cnt_reg  <= '0;
    end else begin
      case (rst_state_reg)
        WKR_HOLD: begin
          if (hold_cnt_reg == HOLD_LAST) begin
            rst_state_reg <= WKR_RUN;
          end
          hold_cnt_reg <= hold_cnt_reg + 1'b1;
        end
        default: begin
          hold_cnt_reg <= '0;
        end
      endcase
    end
  end

  // [R14] pc zero; [R15] ports ones while held
  assign sys_rst_n = !holding;
  assign por_init  = holding;

  // [R9] count clears; [R18] halt clears and resumes if enabled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wdog_cnt_reg <= '0;
    end else if (holding || clear_watchdog_instruction_instr || halt_instr || ovf) begin
      wdog_cnt_reg <= '0;
    end else if (wdog_en && slow_tick_reg) begin
      wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
    end
  end

  // [R8] sleep overflow clears only pc and sp
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_sp_clr_reg <= 1'b0;
    end else begin
      pc_sp_clr_reg <= ovf && sleep_mode;
    end
  end
  assign pc_sp_clr = pc_sp_clr_reg;

  // timeout flag: the overflow wins over a same-cycle clear
  // [R7] timeout set; survives non-power-on resets
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timeout_reg <= 1'b0;
    end else if (ovf) begin
      timeout_reg <= 1'b1;
    end else if (halt_instr || clear_watchdog_instruction_instr) begin
      timeout_reg <= 1'b0;
    end
  end

  // [R19] power-down flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pdown_reg <= 1'b0;
    end else if (halt_instr) begin
      pdown_reg <= 1'b1;
    end else if (clear_watchdog_instruction_instr) begin
      pdown_reg <= 1'b0;
    end
  end

  // ahb address phase capture; zero wait states, always okay
  // hsize is not decoded: every register is one aligned word
  // bits above the 4 KB window are left to the bus decoder
  assign accept    = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // read mux for the address being accepted
  always_comb begin
    rd_val = 8'h00;
    case (reg_decode(haddr[11:2]))
      WKR_SEL_CTRL:  rd_val = wdog_ctrl_reg;
      // [R13] upper cause bits zero
      WKR_SEL_CAUSE: rd_val = {4'h0, cause_reg};
      WKR_SEL_KEY:   rd_val = rst_key_reg;
      WKR_SEL_STAT:  rd_val = {6'h00, pdown_reg, timeout_reg};
      default:       rd_val = 8'h00;
    endcase
  end

  // bus pipeline registers; read data is ready in the data phase
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ap_write_reg <= 1'b0;
      ap_sel_reg   <= WKR_SEL_NONE;
      hrdata_reg   <= 32'h0000_0000;
    end else begin
      ap_write_reg <= accept && hwrite;
      ap_sel_reg   <= accept ? reg_decode(haddr[11:2]) : WKR_SEL_NONE;
      if (accept && !hwrite) begin
        hrdata_reg <= {24'h00_0000, rd_val};
      end
    end
  end

  // control register; reloads while held so a bad key cannot loop
  // [R6] power-on value 0x53
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wdog_ctrl_reg <= `WKR_WDOG_CTRL_RST;
    end else if (holding) begin
      wdog_ctrl_reg <= `WKR_WDOG_CTRL_RST;
    end else if (ap_write_reg && ap_sel_reg == WKR_SEL_CTRL) begin
      wdog_ctrl_reg <= hwdata[7:0];
    end
  end

  // [R11] reset key power-on value
  // a bad value written here is caught by key_bad[1] on later ticks
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_key_reg <= `WKR_RST_KEY_RST;
    end else if (holding) begin
      rst_key_reg <= `WKR_RST_KEY_RST;
    end else if (ap_write_reg && ap_sel_reg == WKR_SEL_KEY) begin
      rst_key_reg <= hwdata[7:0];
    end
  end

  // cause flags: software writes 0 to clear, hardware set wins
  always_comb begin
    cause_next = cause_reg;
    if (ap_write_reg && ap_sel_reg == WKR_SEL_CAUSE) begin
      cause_next = cause_reg & hwdata[3:0];
    end
    // [R5] enable key fault
    if (key_fire[0]) begin
      cause_next[`WKR_BIT_ENKEY_FAULT] = 1'b1;
    end
    // [R12] reset key fault
    if (key_fire[1]) begin
      cause_next[`WKR_BIT_CKEY_FAULT] = 1'b1;
    end
    // [R17] brownout flag
    if (brownout_det) begin
      cause_next[`WKR_BIT_BROWNOUT] = 1'b1;
    end
  end

  // flags kept across every reset except power-on
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cause_reg <= 4'h0;
    end else begin
      cause_reg <= cause_next;
    end
  end

endmodule

`default_nettype wire

//--- wkr_chk.sv
// port assertions for the watchdog and reset-key block
`timescale 1ns/1ps
`default_nettype none

module wkr_chk #(
  parameter int unsigned PWRON_CYC = 16
) (
  input wire logic        ref_clk,      // system clock
  input wire logic        nrst,         // power-on reset
  input wire logic        hsel,         // ahb select
  input wire logic [1:0]  htrans,       // ahb transfer type
  input wire logic        hwrite,       // ahb write
  input wire logic        hready,       // ahb bus ready
  input wire logic        sleep_mode,   // cpu asleep
  input wire logic        brownout_det, // supply low
  input wire logic        hreadyout,    // slave ready
  input wire logic        hresp,        // slave response
  input wire logic [31:0] hrdata,       // read data
  input wire logic        sys_rst_n,    // full reset
  input wire logic        por_init,     // pc and port init
  input wire logic        pc_sp_clr     // pc and sp clear
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  int unsigned low_cnt_reg;

  // cycles of the current reset hold, so its length can be judged
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      low_cnt_reg <= 0;
    else if (sys_rst_n)
      low_cnt_reg <= 0;
    else
      low_cnt_reg <= low_cnt_reg + 1;
  end

  sequence s_read_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_hold_low;
    !sys_rst_n [*8];
  endsequence

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_rdata_stands: assert property (
    !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_por_follow: assert property (por_init == !sys_rst_n)
    else $error("init strobe out of step with reset");
  a_hold_long: assert property ($fell(sys_rst_n) |-> s_hold_low)
    else $error("reset hold too short");
  a_hold_count: assert property (
    $rose(sys_rst_n) |-> low_cnt_reg >= PWRON_CYC - 1)
    else $error("reset released before the delay");
  a_brown_rst: assert property (brownout_det |-> ##[1:2] !sys_rst_n)
    else $error("brownout gave no reset");
  a_pcsp_pulse: assert property (pc_sp_clr |=> !pc_sp_clr)
    else $error("pc and sp clear longer than a cycle");
  a_pcsp_sleep: assert property (
    pc_sp_clr |-> sys_rst_n && $past(sleep_mode))
    else $error("pc and sp clear outside sleep");
  c_read: cover property (s_read_taken);
endmodule

bind wkr_watchdog_reset wkr_chk #(.PWRON_CYC(PWRON_CYC)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .sleep_mode(sleep_mode),
  .brownout_det(brownout_det), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sys_rst_n(sys_rst_n), .por_init(por_init),
  .pc_sp_clr(pc_sp_clr));

`default_nettype wire

//--- tb.sv
// self-checking bench for the watchdog and reset-key block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import wkr_pkg::*;
  localparam int          DIV   = 8;  // short slow-tick divider
  localparam int          HOLD  = 16; // short power-on hold
  localparam logic [31:0] A_CTL = 32'h0;
  localparam logic [31:0] A_CAU = 32'h4;
  localparam logic [31:0] A_KEY = 32'h8;
  localparam logic [31:0] A_ST  = 32'hc;
  logic        ref_clk, nrst, hsel, hwrite, clear_watchdog_instruction_instr, halt_instr;
  logic        sleep_mode, brownout_det, hreadyout, hresp;
  logic        sys_rst_n, por_init, pc_sp_clr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  wire logic   hready;
  int          bad_count, num_checks;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  wkr_watchdog_reset #(.SLOW_RC_OSCILLATOR_DIV(DIV), .PWRON_CYC(HOLD)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .clear_watchdog_instruction_instr(clear_watchdog_instruction_instr),
    .halt_instr(halt_instr), .sleep_mode(sleep_mode),
    .brownout_det(brownout_det), .sys_rst_n(sys_rst_n),
    .por_init(por_init), .pc_sp_clr(pc_sp_clr));

  task automatic chk(input string w, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", w, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // bounded wait on reset level (s=0) or the pc/sp pulse (s=1)
  task automatic waitfor(input int s, input logic v, input int lim,
                         output int n);
    n = 0;
    while ((s ? pc_sp_clr : sys_rst_n) !== v) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > lim) begin
        chk("wait", v, ~v);
        conclude();
      end
    end
  endtask

  // ahb single: address phase, then data phase, each held to hready
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    repeat (2) begin
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) begin
        chk("bus wait", 32'h1, 32'h0);
        conclude();
      end
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
    end
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string w, input logic [31:0] a, m, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(w, e, q & m);
  endtask

  // one-cycle cpu strobe: 1 halt, 0 clear instruction
  task automatic strobe(input int s);
    @(posedge ref_clk);
    if (s)
      halt_instr <= 1'b1;
    else
      clear_watchdog_instruction_instr <= 1'b1;
    @(posedge ref_clk);
    halt_instr <= 1'b0;
    clear_watchdog_instruction_instr <= 1'b0;
  endtask

  task automatic t_reset();
    int n;
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    chk("por_init", 1, por_init);
    waitfor(0, 1'b1, 4 * HOLD, n);
    chk("hold", 1, n >= HOLD - 1);
    rd("ctrl", A_CTL, 32'hff, 32'h53);
    rd("key", A_KEY, 32'hff, 32'h55);
    // power-on also clears every cause flag left by earlier resets
    rd("cause", A_CAU, 32'hff, 0);
    rd("status", A_ST, 32'h3, 0);
    rd("unmapped", 32'h10, 32'hffffffff, 0);
    for (int c = 0; c < 8; c++) begin
      wr(A_CTL, 32'h50 | c);
      rd("psel", A_CTL, 32'hff, 32'h50 | c);
    end
    $display("test reset done");
  endtask

  // clears hold the overflow off; then it comes at 2^n ticks
  task automatic t_period(input int c, p);
    int n;
    wr(A_CTL, 32'h50 | c);
    repeat (3) begin
      repeat (p * DIV * 3 / 4) @(posedge ref_clk);
      strobe(0);
    end
    waitfor(0, 1'b0, p * DIV + 4 * DIV, n);
    chk("period", 1, n >= (p - 1) * DIV - 2);
    waitfor(0, 1'b1, 4 * HOLD, n);
    rd("timeout", A_ST, 32'h1, 32'h1);
    rd("reload", A_CTL, 32'hff, 32'h53);
    $display("test period %0d done", c);
  endtask

  task automatic t_sleep();
    int n;
    wr(A_CTL, 32'ha8);
    repeat (300 * DIV) @(posedge ref_clk);
    chk("disabled", 1, sys_rst_n);
    wr(A_CTL, 32'h50);
    sleep_mode <= 1'b1;
    strobe(1);
    waitfor(1, 1'b1, 260 * DIV, n);
    chk("sleep time", 1, n >= 255 * DIV - 2);
    chk("no full rst", 1, sys_rst_n);
    rd("flags", A_ST, 32'h3, 32'h3);
    strobe(0);
    rd("flags clr", A_ST, 32'h3, 32'h0);
    sleep_mode <= 1'b0;
    wr(A_CTL, 32'ha8);
    $display("test sleep done");
  endtask

  // a bad key value resets after 2..3 ticks and leaves its cause bit
  task automatic t_bad(input logic [31:0] a, v, input int b,
                       input logic [31:0] r);
    int n;
    wr(a, v);
    waitfor(0, 1'b0, 4 * DIV, n);
    chk("key delay", 1, n >= 2 * DIV - 2);
    waitfor(0, 1'b1, 4 * HOLD, n);
    rd("cause set", A_CAU, 1 << b, 1 << b);
    rd("reload", a, 32'hff, r);
    wr(A_CAU, ~(32'h1 << b));
    rd("cause clr", A_CAU, 1 << b, 0);
    $display("test bad key %0d done", b);
  endtask

  task automatic t_misc();
    int n;
    wr(A_KEY, 32'haa);
    repeat (4 * DIV) @(posedge ref_clk);
    chk("key noop", 1, sys_rst_n);
    brownout_det <= 1'b1;
    repeat (3) @(posedge ref_clk);
    brownout_det <= 1'b0;
    #1;
    chk("brownout", 0, sys_rst_n);
    waitfor(0, 1'b1, 4 * HOLD, n);
    rd("brown cause", A_CAU, 32'h4, 32'h4);
    $display("test misc done");
  endtask

  // free-running 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // main sequence
  initial begin
    {nrst, hsel, hwrite, clear_watchdog_instruction_instr, halt_instr} = 5'h0;
    {sleep_mode, brownout_det, htrans} = 4'h0;
    {hsize, haddr, hwdata} = {3'h2, 64'h0};
    t_reset();
    t_period(0, 256);
    t_period(1, 1024);
    t_sleep();
    t_bad(A_CTL, 32'h00, 0, 32'h53);
    t_bad(A_KEY, 32'h12, 3, 32'h55);
    t_misc();
    // second power-on in mid-run must wipe the brownout cause flag
    t_reset();
    conclude();
  end
endmodule

`default_nettype wire
